// File: rtl/current_datapath.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: Decimation, current gain, DC blocking, waveform capture
// Assumes: Modulator bits valid on the modulator tick, word register port
// Notes:   Sample stream buffered in a FIFO that stalls the sequencer
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps

module sample_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_ff[rd_ptr_ff];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

endmodule // sample_fifo

////////////////////////////////////////////////////////////////////////////////

module current_datapath
	import meter_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               master_clock_pin,
	input  wire logic [1:0]         power_mode,
	input  wire logic [NUM_CH-1:0]  mod_bits,
	output logic                    modulator_clock,
	output logic [NUM_CH-1:0]       converter_on,
	input  wire logic [15:0]        reg_addr,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic [31:0]        reg_wdata,
	output logic [31:0]             reg_rdata,
	output logic                    reg_rvalid,
	output logic                    irq_n,
	output logic                    stream_valid,
	input  wire logic               stream_ready,
	output sample_word_t            stream_data
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic signed [23:0] sat24(input logic signed [25:0] v);
		if (v > 26'(SAMPLE_MAX)) begin
			sat24 = SAMPLE_MAX;
		end else if (v < 26'(SAMPLE_MIN)) begin
			sat24 = SAMPLE_MIN;
		end else begin
			sat24 = v[23:0];
		end
	endfunction

	function automatic logic chan_active(input logic [1:0] mode, input int ch);
		case (mode)
			FULL_POWER_MODE:    chan_active = 1'b1;
			REDUCED_POWER_MODE: chan_active = (ch < NUM_CUR - 1);
			default:            chan_active = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Modulator clock and decimation timing

	logic       mclk_d_ff;
	logic [3:0] mclk_cnt_ff;
	logic       mod_clk_ff;
	logic [6:0] dec_cnt_ff;
	logic       mclk_rise;
	logic       mod_tick;
	logic       dec_point;

	assign mclk_rise = master_clock_pin && !mclk_d_ff;
	assign mod_tick  = mclk_rise && (mclk_cnt_ff == 4'(MCLK_DIV - 1));
	assign dec_point = mod_tick && (dec_cnt_ff == 7'(DECIM - 1));
	assign modulator_clock = mod_clk_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			mclk_d_ff   <= 1'b0;
			mclk_cnt_ff <= '0;
			mod_clk_ff  <= 1'b0;
		end else begin
			mclk_d_ff <= master_clock_pin;
			if (mclk_rise) begin
				mclk_cnt_ff <= mclk_cnt_ff + 1'b1;
				if (mclk_cnt_ff == 4'(MCLK_DIV/2 - 1)) begin
					mod_clk_ff <= 1'b0;
				end else if (mod_tick) begin
					mod_clk_ff <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dec_cnt_ff <= '0;
		end else if (dec_point) begin
			dec_cnt_ff <= '0;
		end else if (mod_tick) begin
			dec_cnt_ff <= dec_cnt_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Third-order averaging decimators, one per converter

	logic signed [23:0] dec_ff [NUM_CH];
	logic [NUM_CH-1:0]  dec_new;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_cic
			logic signed [CIC_W-1:0] i1_ff, i2_ff, i3_ff;
			logic signed [CIC_W-1:0] d1_ff, d2_ff, d3_ff;
			logic signed [CIC_W-1:0] in_v, c1, c2, c3;

			assign converter_on[g] = chan_active(power_mode, g);
			assign in_v = mod_bits[g] ? CIC_W'(1) : -CIC_W'(1);
			assign c1 = i3_ff - d1_ff;
			assign c2 = c1 - d2_ff;
			assign c3 = c2 - d3_ff;
			assign dec_new[g] = dec_point && converter_on[g];

			always_ff @(posedge clk) begin
				if (reset || !converter_on[g]) begin
					i1_ff <= '0;
					i2_ff <= '0;
					i3_ff <= '0;
					d1_ff <= '0;
					d2_ff <= '0;
					d3_ff <= '0;
				end else if (mod_tick) begin
					i1_ff <= i1_ff + in_v;
					i2_ff <= i2_ff + i1_ff;
					i3_ff <= i3_ff + i2_ff;
					if (dec_point) begin
						d1_ff <= i3_ff;
						d2_ff <= c1;
						d3_ff <= c2;
					end
				end
			end

			always_ff @(posedge clk) begin
				if (reset) begin
					dec_ff[g] <= '0;
				end else if (dec_new[g]) begin
					dec_ff[g] <= sat24(c3 <<< CIC_SCALE);
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic signed [23:0] gain_ff [NUM_CUR];
	logic signed [23:0] wave_ff [NUM_CUR];
	logic               dc_block_enable_ff;
	logic               sample_available_flag_ff;
	logic               mask_ff;
	logic               flag_set;
	logic [31:0]        nxt_rdata;

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_CUR; i++) begin
				gain_ff[i] <= '0;
			end
			dc_block_enable_ff <= THIRD_CONFIG_RESET;
			mask_ff            <= 1'b0;
		end else if (reg_wr) begin
			for (int i = 0; i < NUM_CUR; i++) begin
				if (reg_addr == ADDR_GAIN_BASE + 16'(i)) begin
					gain_ff[i] <= reg_wdata[23:0];
				end
			end
			if (reg_addr == ADDR_THIRD_CONFIG) begin
				dc_block_enable_ff <= reg_wdata[DC_BLOCK_EN_BIT];
			end else if (reg_addr == ADDR_FIRST_MASK) begin
				mask_ff <= reg_wdata[SAMPLE_AVAIL_BIT];
			end
		end
	end

	// Set beats a simultaneous write-one clear so no sample event is lost
	always_ff @(posedge clk) begin
		if (reset) begin
			sample_available_flag_ff <= 1'b0;
		end else if (flag_set) begin
			sample_available_flag_ff <= 1'b1;
		end else if (reg_wr && reg_addr == ADDR_FIRST_STATUS &&
		             reg_wdata[SAMPLE_AVAIL_BIT]) begin
			sample_available_flag_ff <= 1'b0;
		end
	end

	assign irq_n = !(sample_available_flag_ff && mask_ff);

	always_comb begin
		nxt_rdata = '0;
		for (int i = 0; i < NUM_CUR; i++) begin
			if (reg_addr == ADDR_GAIN_BASE + 16'(i)) begin
				nxt_rdata = {4'h0, {4{gain_ff[i][23]}}, gain_ff[i]};
			end else if (reg_addr == ADDR_SAMPLE_BASE + 16'(i)) begin
				nxt_rdata = {{8{wave_ff[i][23]}}, wave_ff[i]};
			end
		end
		if (reg_addr == ADDR_THIRD_CONFIG) begin
			nxt_rdata[DC_BLOCK_EN_BIT] = dc_block_enable_ff;
		end else if (reg_addr == ADDR_FIRST_STATUS) begin
			nxt_rdata[SAMPLE_AVAIL_BIT] = sample_available_flag_ff;
		end else if (reg_addr == ADDR_FIRST_MASK) begin
			nxt_rdata[SAMPLE_AVAIL_BIT] = mask_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= nxt_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel sequencer: gain, DC block, capture, push. One shared multiplier.

	seq_state_t         state_ff;
	logic [2:0]         ch_ff;
	logic [NUM_CH-1:0]  pend_ff;
	logic signed [31:0] dc_ff [NUM_CH];
	logic signed [23:0] x;
	logic signed [23:0] gsel;
	logic signed [47:0] prod;
	logic signed [25:0] scaled_sum;
	logic signed [23:0] scaled;
	logic signed [32:0] dc_diff;
	logic signed [31:0] nxt_dc;
	logic signed [23:0] hpf_out;
	logic               is_cur;
	logic               fifo_in_ready;
	logic               step;
	sample_word_t       push_word;
	logic               push_valid;

	assign is_cur  = (ch_ff < 3'(NUM_CUR));
	assign x       = dec_ff[ch_ff];
	assign gsel    = is_cur ? gain_ff[ch_ff[1:0]] : '0;
	assign prod    = x * gsel;
	assign scaled_sum = 26'(x) + 26'(prod >>> GAIN_FRAC);
	assign scaled  = sat24(scaled_sum);
	// Sign-extend before scaling so negative samples pull the offset down
	assign dc_diff = (33'(scaled) <<< DC_FRAC) - 33'(dc_ff[ch_ff]);
	assign nxt_dc  = dc_ff[ch_ff] + 32'(dc_diff >>> HPF_SHIFT);
	assign hpf_out = dc_block_enable_ff ?
		sat24(26'(scaled) - 26'(dc_ff[ch_ff] >>> DC_FRAC)) : scaled;

	assign push_valid      = (state_ff == SEQ_RUN) && pend_ff[ch_ff];
	assign push_word.chan  = ch_ff;
	assign push_word.value = hpf_out;
	// A full FIFO holds the sequencer on the current channel
	assign step     = (state_ff == SEQ_RUN) && (!pend_ff[ch_ff] || fifo_in_ready);
	assign flag_set = step && pend_ff[ch_ff] && (ch_ff == 3'(NUM_CUR - 1));

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= SEQ_IDLE;
			ch_ff    <= '0;
			pend_ff  <= '0;
		end else begin
			case (state_ff)
				SEQ_IDLE: begin
					if (dec_new != '0) begin
						pend_ff  <= dec_new;
						ch_ff    <= '0;
						state_ff <= SEQ_RUN;
					end
				end
				SEQ_RUN: begin
					if (step) begin
						if (ch_ff == 3'(NUM_CH - 1)) begin
							state_ff <= SEQ_IDLE;
						end else begin
							ch_ff <= ch_ff + 1'b1;
						end
					end
				end
				default: begin
					state_ff <= SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_CH; i++) begin
				dc_ff[i] <= '0;
			end
		end else if (step && pend_ff[ch_ff] && dc_block_enable_ff) begin
			dc_ff[ch_ff] <= nxt_dc;
		end
	end

	// Capture never touches the pipeline, so downstream math keeps running
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_CUR; i++) begin
				wave_ff[i] <= '0;
			end
		end else if (step && pend_ff[ch_ff] && is_cur) begin
			wave_ff[ch_ff[1:0]] <= hpf_out;
		end
	end

	sample_fifo #(
		.WIDTH ($bits(sample_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (push_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (stream_valid),
		.out_ready (stream_ready),
		.out_data  (stream_data)
	);

endmodule // current_datapath

// File: rtl/meter_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: Constants, types and register map of the current datapath
// Assumes: 100 MHz core clock, master clock pin sampled synchronously
// Notes:   Functional notes below, one line each
//
// Functional notes
// - Full power: all seven converters run
// - Reduced power: only three phase currents run
// - Low power and sleep: all converters off
// - Modulator clock is master clock over sixteen
// - Averaging filter turns bitstream into 24-bit words
// - Signed 24-bit result saturates at full range
// - Current samples come out at 8 kSPS
// - Current scaled by one plus gain over 2^23
// - Scaled current feeds everything, waveforms included
// - Gain reads back sign-extended to 28, top zero
// - DC-blocking filter on every channel after gain
// - One enable bit 0, resets on, zero bypasses
// - Filter outputs latched into four waveform registers
// - Fresh channel 3 waveform sets status bit 17, so full power only
// - Mask bit 17 lets the flag interrupt
// - Waveform reads sign-extended to 32 bits
////////////////////////////////////////////////////////////////////////////////
package meter_pkg;

	localparam int NUM_CH       = 7;
	localparam int NUM_CUR      = 4;
	localparam int CIC_W        = 26;
	localparam int SAMPLE_W     = 24;
	localparam int DC_FRAC      = 8;
	localparam int HPF_SHIFT    = 10;
	localparam int GAIN_FRAC    = 23;
	localparam int FIFO_DEPTH   = 32;

	// Timing: master clock 16.384 MHz, modulator 1.024 MHz, output 8 kSPS
	localparam int MCLK_DIV       = 16;
	localparam int MOD_RATE_HZ    = 1024000;
	localparam int SAMPLE_RATE_HZ = 8000;
	localparam int DECIM          = MOD_RATE_HZ / SAMPLE_RATE_HZ;
	localparam int CIC_SCALE      = 2;

	localparam logic [1:0] FULL_POWER_MODE    = 2'h0;
	localparam logic [1:0] REDUCED_POWER_MODE = 2'h1;
	localparam logic [1:0] LOW_POWER_MODE     = 2'h2;
	localparam logic [1:0] SLEEP_MODE         = 2'h3;

	// Register addresses
	localparam logic [15:0] ADDR_GAIN_BASE    = 16'h0000;
	localparam logic [15:0] ADDR_SAMPLE_BASE  = 16'h0010;
	localparam logic [15:0] ADDR_THIRD_CONFIG = 16'h0020;
	localparam logic [15:0] ADDR_FIRST_STATUS = 16'h0030;
	localparam logic [15:0] ADDR_FIRST_MASK   = 16'h0040;

	localparam int DC_BLOCK_EN_BIT       = 0;
	localparam int SAMPLE_AVAIL_BIT      = 17;
	localparam logic THIRD_CONFIG_RESET  = 1'b1;

	localparam logic signed [23:0] SAMPLE_MAX = 24'sh7fffff;
	localparam logic signed [23:0] SAMPLE_MIN = -24'sh800000;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_RUN  = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic [2:0]  chan;
		logic [23:0] value;
	} sample_word_t;

endpackage

// File: tb/current_datapath_chk.sv
// Purpose: Port-level assertions for the current datapath
// Assumes: Register answer registered one cycle after the read strobe
// Notes:   Bound to the design from the testbench top file
`timescale 1ns/10ps

module current_datapath_chk
	import meter_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [1:0]        power_mode,
	input  wire logic [NUM_CH-1:0] converter_on,
	input  wire logic              modulator_clock,
	input  wire logic [15:0]       reg_addr,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic [31:0]       reg_rdata,
	input  wire logic              reg_rvalid,
	input  wire logic              irq_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

////////////////////////////////////////////////////////////////////////////////
	property p_full;
		power_mode == FULL_POWER_MODE |-> converter_on == 7'h7f;
	endproperty
	a_full: assert property (p_full)
		else $error("converter missing in full power");
	property p_reduced;
		power_mode == REDUCED_POWER_MODE |-> converter_on == 7'h07;
	endproperty
	a_reduced: assert property (p_reduced)
		else $error("wrong converters in reduced power");
	property p_off;
		power_mode[1] |-> converter_on == 7'h00;
	endproperty
	a_off: assert property (p_off)
		else $error("converter running in low power");
	// Shortest high phase is eight master edges, never under eight cycles
	property p_mod_high;
		$rose(modulator_clock) |-> modulator_clock [*8];
	endproperty
	a_mod_high: assert property (p_mod_high)
		else $error("modulator clock high phase too short");
	property p_rvalid;
		reg_rvalid == $past(reg_rd);
	endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read answer not one cycle after request");
	property p_wave_sext;
		reg_rd && reg_addr[15:2] == ADDR_SAMPLE_BASE[15:2]
			|=> reg_rdata[31:24] == {8{reg_rdata[23]}};
	endproperty
	a_wave_sext: assert property (p_wave_sext)
		else $error("sample read not sign extended");
	property p_gain_fmt;
		reg_rd && reg_addr[15:2] == ADDR_GAIN_BASE[15:2] |=>
			reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}};
	endproperty
	a_gain_fmt: assert property (p_gain_fmt)
		else $error("gain read format wrong");
	property p_cfg_bits;
		reg_rd && reg_addr == ADDR_THIRD_CONFIG |=> reg_rdata[31:1] == 31'h0;
	endproperty
	a_cfg_bits: assert property (p_cfg_bits)
		else $error("config read has stray bits");
	property p_mask_off;
		reg_wr && reg_addr == ADDR_FIRST_MASK && !reg_wdata[SAMPLE_AVAIL_BIT]
			|=> irq_n;
	endproperty
	a_mask_off: assert property (p_mask_off)
		else $error("interrupt with mask cleared");

////////////////////////////////////////////////////////////////////////////////
	c_irq: cover property (reg_rvalid && !irq_n);
	c_reduced: cover property (power_mode == REDUCED_POWER_MODE);
	c_sleep: cover property (power_mode == SLEEP_MODE);
endmodule // current_datapath_chk

// File: tb/host_model.sv
// Purpose: Host side of the register word port
// Assumes: Requests launched just after a rising edge
// Notes:   Idle address shows the inverse of the last request, idle data that of the last write
`timescale 1ns/10ps

module host_model (
	input  wire logic        clk,
	output logic [15:0]      reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [31:0]      reg_wdata,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	initial begin
		reg_addr = 16'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0;
	end

	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask

	// A missing answer returns unknown so the caller's compare fails
	task automatic rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		// Address stays put until the answer is sampled with its valid
		@(posedge clk);
		v = (reg_rvalid === 1'b1) ? reg_rdata : 32'hx;
		reg_addr <= ~a;
	endtask
endmodule // host_model

// File: tb/tb_current_datapath.sv
// Purpose: Self-checking bench for the current datapath
// Assumes: Master clock at a sixth of the core clock, currents full scale
// Notes:   Voltage bits and stream stalls are random
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end

module tb_current_datapath
	import meter_pkg::*;
;
	logic              clk, reset, master_clock_pin, stream_ready;
	logic [1:0]        power_mode, mdiv;
	logic [NUM_CH-1:0] mod_bits, converter_on;
	logic [15:0]       reg_addr;
	logic              reg_wr, reg_rd, reg_rvalid, irq_n;
	logic [31:0]       reg_wdata, reg_rdata, d;
	logic              modulator_clock, stream_valid, mon_on, seeded;
	sample_word_t      stream_data;
	logic [2:0]        nxt_ch;
	logic [23:0]       gt [4];
	logic [23:0]       ex [4];
	logic [23:0]       last_val [NUM_CH];
	int                fails, n_compared;

	current_datapath dut (.clk(clk), .reset(reset),
		.master_clock_pin(master_clock_pin), .power_mode(power_mode),
		.mod_bits(mod_bits), .modulator_clock(modulator_clock),
		.converter_on(converter_on), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .irq_n(irq_n), .stream_valid(stream_valid),
		.stream_ready(stream_ready), .stream_data(stream_data));
	host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		mdiv <= (mdiv == 2'd2) ? 2'd0 : mdiv + 2'd1;
		if (mdiv == 2'd2) master_clock_pin <= ~master_clock_pin;
		mod_bits <= {3'($urandom), 4'hf};
		stream_ready <= ($urandom % 4) != 0;
		if (mon_on && stream_valid && stream_ready) begin
			seeded <= 1'b1;
			last_val[stream_data.chan] <= stream_data.value;
			if (seeded) `CHK(stream_data.chan, nxt_ch)
			nxt_ch <= (stream_data.chan == 3'd6) ? 3'd0 : stream_data.chan + 3'd1;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Full-scale input times one plus the gain, clipped at the top of the signed 24-bit range
	function automatic logic [23:0] scale(input logic [23:0] g);
		longint y;
		y = 64'sd8388607 + ((64'sd8388607 * longint'($signed(g))) >>> 23);
		if (y > 64'sd8388607) y = 64'sd8388607;
		return y[23:0];
	endfunction

	task automatic close_out();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic wait_flag();
		int n;
		host.wr(ADDR_FIRST_STATUS, 32'h0002_0000);
		#1;
		`CHK(irq_n, 1'b1)
		n = 0;
		while (irq_n !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) begin
			fails++;
			close_out();
		end
	endtask

////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(45829));
		reset = 1'b1;
		{master_clock_pin, mdiv, mon_on, seeded, nxt_ch} = '0;
		power_mode = FULL_POWER_MODE;
		mod_bits = 7'h0f;
		stream_ready = 1'b0;
		fails = 0;
		n_compared = 0;
		gt = '{24'hc00000, 24'h400000, 24'h000000, 24'he00000};
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		host.rd(ADDR_THIRD_CONFIG, d);
		`CHK(d, 32'h1)
		host.rd(16'h0050, d);
		`CHK(d, 32'h0)
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			power_mode <= 2'(m);
			@(posedge clk);
			#1;
			`CHK(converter_on, m == 0 ? 7'h7f : m == 1 ? 7'h07 : 7'h00)
		end
		$display("test power modes done");
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			ex[i] = d[23:0];
			host.wr(ADDR_GAIN_BASE + 16'(i), d);
			host.rd(ADDR_GAIN_BASE + 16'(i), d);
			`CHK(d, {4'h0, {4{ex[i][23]}}, ex[i]})
		end
		$display("test gain readback done");
		@(posedge clk);
		power_mode <= FULL_POWER_MODE;
		for (int i = 0; i < 4; i++) begin
			host.wr(ADDR_GAIN_BASE + 16'(i), {8'h0, gt[i]});
			ex[i] = scale(gt[i]);
		end
		host.wr(ADDR_THIRD_CONFIG, 32'h0);
		host.wr(ADDR_FIRST_MASK, 32'h0002_0000);
		mon_on <= 1'b1;
		// Decimator restarts after sleep; four samples let it settle
		repeat (4) wait_flag();
		host.wr(ADDR_SAMPLE_BASE, 32'h0);
		host.rd(ADDR_FIRST_STATUS, d);
		`CHK(d[SAMPLE_AVAIL_BIT], 1'b1)
		`CHK(irq_n, 1'b0)
		for (int i = 0; i < 4; i++) begin
			host.rd(ADDR_SAMPLE_BASE + 16'(i), d);
			`CHK(d, {{8{ex[i][23]}}, ex[i]})
		end
		for (int i = 0; i < 4; i++) begin
			`CHK(last_val[i], ex[i])
		end
		$display("test gain datapath done");
		host.wr(ADDR_FIRST_MASK, 32'h0);
		host.wr(ADDR_FIRST_STATUS, 32'h0002_0000);
		// One sample period is 12288 cycles at this master rate
		repeat (12400) @(posedge clk);
		host.rd(ADDR_FIRST_STATUS, d);
		`CHK(d[SAMPLE_AVAIL_BIT], 1'b1)
		`CHK(irq_n, 1'b1)
		$display("test mask done");
		host.wr(ADDR_FIRST_MASK, 32'h0002_0000);
		host.wr(ADDR_THIRD_CONFIG, 32'h1);
		// First sample after enabling still sees a zero offset estimate
		repeat (2) wait_flag();
		host.rd(ADDR_SAMPLE_BASE, d);
		`CHK($signed(d[23:0]) < $signed(ex[0]), 1'b1)
		$display("test dc block done");
		close_out();
	end
endmodule // tb_current_datapath

bind current_datapath current_datapath_chk chk (.clk(clk), .reset(reset),
	.power_mode(power_mode), .converter_on(converter_on),
	.modulator_clock(modulator_clock), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq_n(irq_n));
